// [icl_pkg.sv]
// shared constants and types for the instruction cache lock, boot and replacement control
`default_nettype none
package icl_pkg;
    // cache geometry
    localparam int WAYS = 8;
    localparam int SETS = 64;
    localparam int BLOCKS = 512;
    localparam int SET_LSB = 6;
    localparam int SET_MSB = 11;
    localparam int TAG_LSB = 12;
    // register offsets inside the control space
    localparam logic [23:0] OFS_LOCK_CTL  = 24'h100210;
    localparam logic [23:0] OFS_LOCK_BASE = 24'h100214;
    localparam logic [23:0] OFS_LOCK_SIZE = 24'h100218;
    // field positions
    localparam int CTL_EN_BIT = 0;
    localparam int BASE_LSB = 6;
    localparam int SIZE_LSB = 6;
    localparam int SIZE_MSB = 14;
    // locking limits: half the cache, four ways of a set
    localparam logic [8:0] MAX_LOCK_BLOCKS = 9'h100;
    localparam logic [3:0] MAX_LOCK_WAYS = 4'h4;
    // boot scan: one cycle per block
    localparam int BOOT_CYCLES = 512;
    localparam logic [8:0] SCAN_LAST = 9'h1FF;
    // lru layout: pair bits above the six matrix bits
    localparam int PAIR_LSB = 6;
    localparam logic [9:0] LRU_INIT = 10'h029;

    typedef enum logic [2:0] {
        ST_HOLD = 3'b000,
        ST_SCAN = 3'b001,
        ST_IDLE = 3'b010,
        ST_FILL = 3'b011,
        ST_LREQ = 3'b100,
        ST_LACT = 3'b101
    } icl_state_t;

    typedef enum logic [1:0] {
        SCAN_BOOT = 2'b00,
        SCAN_LOCK = 2'b01,
        SCAN_CLR  = 2'b10
    } icl_scan_t;

    // bit position of matrix element R[hi,lo], hi above lo
    function automatic logic [2:0] icl_rpos(input logic [1:0] hi, input logic [1:0] lo);
        case ({hi, lo})
            4'h4: icl_rpos = 3'h5;
            4'h9: icl_rpos = 3'h4;
            4'h8: icl_rpos = 3'h3;
            4'hE: icl_rpos = 3'h2;
            4'hD: icl_rpos = 3'h1;
            default: icl_rpos = 3'h0;
        endcase
    endfunction
endpackage
`default_nettype wire

// [icl_lru.sv]
// hierarchical lru of one set: update on reference and lock-aware victim choice
`default_nettype none
module icl_lru import icl_pkg::*; (
    input  wire logic [9:0] lruState,
    input  wire logic [7:0] lockMask,
    input  wire logic [2:0] refWay,
    output logic      [9:0] lruNext,
    output logic      [2:0] victim
);
    // reference: row of the pair to one, its column to zero, pair bit plain write
    always_comb begin
        lruNext = lruState;
        for (int m = 0; m < 4; m++) begin
            if (2'(m) < refWay[2:1]) begin
                lruNext[icl_rpos(refWay[2:1], 2'(m))] = 1'b1; // see R17
            end else if (2'(m) > refWay[2:1]) begin
                lruNext[icl_rpos(2'(m), refWay[2:1])] = 1'b0; // see R17
            end
        end
        lruNext[PAIR_LSB + int'(refWay[2:1])] = ~refWay[0]; // see R14 see R15 see R18
    end

    // victim: oldest pair that still has an unlocked way, then its lru element
    always_comb begin
        logic [2:0] rank;
        logic [2:0] bestRank;
        logic [1:0] bestPair;
        logic       q;
        rank = 3'h0;
        bestRank = 3'h7;
        bestPair = 2'h0;
        q = 1'b0;
        for (int k = 0; k < 4; k++) begin
            rank = 3'h0;
            for (int m = 0; m < 4; m++) begin
                if (m < k && lruState[icl_rpos(2'(k), 2'(m))]) begin
                    rank = rank + 3'h1;
                end else if (m > k && !lruState[icl_rpos(2'(m), 2'(k))]) begin
                    rank = rank + 3'h1;
                end
            end
            // a fully locked pair is never a candidate
            if (!(lockMask[2 * k] && lockMask[2 * k + 1]) && rank < bestRank) begin // see R02
                bestRank = rank;
                bestPair = 2'(k);
            end
        end
        q = lruState[PAIR_LSB + int'(bestPair)]; // see R16
        if (lockMask[{bestPair, q}]) begin
            q = ~q; // see R02
        end
        victim = {bestPair, q}; // see R13 see R18
    end
endmodule
`default_nettype wire

// [icl_ctrl.sv]
// instruction cache control: lock sequence, boot scan, tag lookup and replacement
// Overview of operation
// R01: lock at most half, four ways per set
// R02: locked blocks never chosen as victim
// R03: lock enable: invalidate, preload range, then lock
// R04: no write-back before lock invalidation
// R05: software keeps locked code in one range
// R06: cache clear also invalidates locked blocks
// R07: software disables locking before cache clear
// R08: external initiators should not enable locking
// R09: during reset force nops, load boot vector
// R10: after reset stall, clear valids, release
// R11: boot scan lasts 512 cycles, one per block
// R12: boot vector resets to aperture base value
// R13: four pairs, four-way then two-way lru
// R14: pair bit written on every hit, no rmw
// R15: even hit writes one, odd writes zero
// R16: pair bit zero replaces even, one odd
// R17: pair reference sets row, clears column
// R18: hit way j: pair j/2, bit j%2
// R19: reset matrix and pair bits to legal state
// R20: core stalled during lock invalidate and preload
// R21: lock range in 64-byte blocks, normal fill
`default_nettype none
module icl_ctrl import icl_pkg::*; #(
    parameter logic [31:0] APERTURE_BASE_RESET = 32'h0000_0000
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        regSel,
    input  wire logic        regWrite,
    input  wire logic [23:0] regOffset,
    input  wire logic [31:0] regWdata,
    output logic      [31:0] regRdata,
    input  wire logic        fetchReq,
    input  wire logic [31:0] fetchAddr,
    output logic             fetchHit,
    output logic      [2:0]  hitWay,
    output logic             coreStall,
    output logic             nopForce,
    output logic             pcLoad,
    output logic      [31:0] bootVector,
    input  wire logic        iclrReq,
    output logic             fillReq,
    output logic      [25:0] fillBlockAddr,
    output logic      [2:0]  fillWay,
    input  wire logic        fillDone
);
    typedef struct packed {
        icl_state_t               state;
        icl_scan_t                kind;
        logic [8:0]               cnt;
        logic [8:0]               blkIdx;
        logic [BLOCKS-1:0]        valid;
        logic [BLOCKS-1:0]        locked;
        logic [BLOCKS-1:0]        pend;
        logic [SETS-1:0][9:0]     lru;
        logic                     ctrlEn;
        logic                     lockStart;
        logic [25:0]              baseBlk;
        logic [8:0]               sizeBlk;
        logic [25:0]              fillAddr;
        logic [2:0]               fillWay;
        logic                     fillLock;
        logic                     fillReq;
        logic [2:0]               hitWay;
        logic [31:0]              rdata;
        logic [31:0]              bootVec;
    } icl_ctl_t;

    icl_ctl_t    q;
    icl_ctl_t    d;
    logic [19:0] tagMem [BLOCKS];
    logic [7:0]  wayHit;
    logic [7:0]  setMask;
    logic        anyHit;
    logic [2:0]  hitEnc;
    logic [5:0]  fetchSet;
    logic [5:0]  selSet;
    logic [2:0]  refWay;
    logic [9:0]  lruNext;
    logic [2:0]  victim;
    logic [25:0] lockBlk;
    logic [8:0]  lockLimit;
    logic [3:0]  lockedInSet;
    logic [8:0]  fillIdx;
    logic        idleFree;
    logic        selCtl;
    logic        selBase;
    logic        selSize;

    function automatic logic [2:0] icl_enc(input logic [7:0] oneHot);
        icl_enc = 3'h0;
        for (int w = 0; w < WAYS; w++) begin
            if (oneHot[w]) begin
                icl_enc = 3'(w);
            end
        end
    endfunction

    function automatic logic [3:0] icl_count(input logic [7:0] bits);
        icl_count = 4'h0;
        for (int w = 0; w < WAYS; w++) begin
            icl_count = icl_count + {3'h0, bits[w]};
        end
    endfunction

    // address split and which set the shared lru port looks at
    assign fetchSet = fetchAddr[SET_MSB:SET_LSB];
    assign lockBlk = q.baseBlk + {17'h0, q.blkIdx};
    assign selSet = (q.state == ST_FILL) ? q.fillAddr[5:0] :
                    (q.state == ST_LREQ) ? lockBlk[5:0] : fetchSet;
    assign fillIdx = {q.fillAddr[5:0], q.fillWay};

    // per-way tag compare and lock mask of the selected set
    for (genvar w = 0; w < WAYS; w++) begin : g_way
        assign wayHit[w] = q.valid[{fetchSet, 3'(w)}] &&
                           tagMem[{fetchSet, 3'(w)}] == fetchAddr[31:TAG_LSB];
        assign setMask[w] = q.locked[{selSet, 3'(w)}] | q.pend[{selSet, 3'(w)}];
    end

    assign anyHit = |wayHit;
    assign hitEnc = icl_enc(wayHit);
    assign refWay = (q.state == ST_FILL) ? q.fillWay : hitEnc;
    assign lockedInSet = icl_count(setMask);
    // range is counted in whole blocks and capped at half the cache
    assign lockLimit = (q.sizeBlk > MAX_LOCK_BLOCKS) ? MAX_LOCK_BLOCKS : q.sizeBlk; // see R01 see R21

    icl_lru u_lru (
        .lruState (q.lru[selSet]),
        .lockMask (setMask),
        .refWay   (refWay),
        .lruNext  (lruNext),
        .victim   (victim)
    );

    // register decode
    assign selCtl = regSel && regOffset == OFS_LOCK_CTL;
    assign selBase = regSel && regOffset == OFS_LOCK_BASE;
    assign selSize = regSel && regOffset == OFS_LOCK_SIZE;

    // fetches are served only when no sequence is about to start
    assign idleFree = q.state == ST_IDLE && !q.lockStart && !iclrReq;
    assign fetchHit = idleFree && fetchReq && anyHit;
    assign coreStall = !idleFree || (fetchReq && !anyHit); // see R10 see R20
    assign nopForce = q.state == ST_HOLD; // see R09
    assign pcLoad = q.state == ST_HOLD; // see R09
    assign bootVector = q.bootVec;
    assign hitWay = q.hitWay;
    assign fillReq = q.fillReq;
    assign fillBlockAddr = q.fillAddr;
    assign fillWay = q.fillWay;
    assign regRdata = q.rdata;

    // next-state logic of the whole controller
    always_comb begin
        d = q;
        case (q.state)
            ST_HOLD: begin
                d.state = ST_SCAN; // see R10
                d.kind = SCAN_BOOT;
                d.cnt = '0;
            end
            ST_SCAN: begin
                // one block per cycle, the set lru reset as we pass it
                d.valid[q.cnt] = 1'b0; // see R10 see R06
                d.lru[q.cnt[8:3]] = LRU_INIT;
                if (q.cnt == SCAN_LAST) begin // see R11
                    d.blkIdx = '0;
                    d.state = (q.kind == SCAN_LOCK) ? ST_LREQ : ST_IDLE; // see R03
                end else begin
                    d.cnt = q.cnt + 9'h001;
                end
            end
            ST_IDLE: begin
                if (q.lockStart) begin
                    // nothing can be dirty, so invalidation starts at once
                    d.lockStart = 1'b0;
                    d.state = ST_SCAN; // see R03 see R04
                    d.kind = SCAN_LOCK;
                    d.cnt = '0;
                    d.locked = '0;
                    d.pend = '0;
                end else if (iclrReq) begin
                    d.state = ST_SCAN;
                    d.kind = SCAN_CLR;
                    d.cnt = '0;
                    d.locked = '0; // see R06
                    d.pend = '0;
                end else if (fetchReq && anyHit) begin
                    d.lru[selSet] = lruNext; // see R14 see R18
                    d.hitWay = hitEnc;
                end else if (fetchReq) begin
                    d.fillAddr = fetchAddr[31:SET_LSB];
                    d.fillWay = victim; // see R02 see R16
                    d.fillLock = 1'b0;
                    d.fillReq = 1'b1;
                    d.state = ST_FILL;
                end
            end
            ST_FILL: begin
                if (fillDone) begin
                    d.valid[fillIdx] = 1'b1;
                    d.pend[fillIdx] = q.fillLock;
                    d.lru[selSet] = lruNext;
                    d.fillReq = 1'b0;
                    d.blkIdx = q.blkIdx + {8'h00, q.fillLock};
                    d.state = q.fillLock ? ST_LREQ : ST_IDLE;
                end
            end
            ST_LREQ: begin
                // a disable during the preload ends it with nothing locked
                if (q.blkIdx == lockLimit || !q.ctrlEn) begin
                    d.state = ST_LACT;
                end else if (lockedInSet >= MAX_LOCK_WAYS) begin
                    // set already holds its share of locked ways: skip the block
                    d.blkIdx = q.blkIdx + 9'h001; // see R01
                end else begin
                    // preload goes through the ordinary miss fill path
                    d.fillAddr = lockBlk; // see R21
                    d.fillWay = victim;
                    d.fillLock = 1'b1;
                    d.fillReq = 1'b1;
                    d.state = ST_FILL; // see R03
                end
            end
            ST_LACT: begin
                d.locked = q.ctrlEn ? q.pend : '0; // see R03 see R02
                d.pend = '0;
                d.state = ST_IDLE;
            end
            default: begin
                d.state = ST_IDLE;
            end
        endcase
        // register writes come last so a new enable wins over the idle clear
        if (regSel && regWrite) begin
            if (selCtl) begin
                d.ctrlEn = regWdata[CTL_EN_BIT];
                if (regWdata[CTL_EN_BIT] && !q.ctrlEn) begin
                    d.lockStart = 1'b1; // see R03
                end else if (!regWdata[CTL_EN_BIT]) begin
                    // unlocking leaves contents valid but replaceable
                    d.lockStart = 1'b0;
                    d.locked = '0; // see R02
                    d.pend = '0;
                end
            end
            if (selBase) begin
                d.baseBlk = regWdata[31:BASE_LSB]; // see R21
            end
            if (selSize) begin
                d.sizeBlk = regWdata[SIZE_MSB:SIZE_LSB];
            end
        end
        // reads answer the next cycle; unmapped offsets read zero
        d.rdata = '0;
        if (regSel && !regWrite) begin
            if (selCtl) begin
                d.rdata = 32'(q.ctrlEn) << CTL_EN_BIT;
            end else if (selBase) begin
                d.rdata = 32'(q.baseBlk) << BASE_LSB;
            end else if (selSize) begin
                d.rdata = 32'(q.sizeBlk) << SIZE_LSB;
            end
        end
    end

    // state register; reset holds the core on nops with the boot vector loaded
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q <= '0;
            q.lru <= {SETS{LRU_INIT}}; // see R19
            q.bootVec <= APERTURE_BASE_RESET; // see R12
        end else begin
            q <= d;
        end
    end

    // tag storage needs no reset: valid bits guard it
    always_ff @(posedge clk) begin
        if (q.state == ST_FILL && fillDone) begin
            tagMem[fillIdx] <= q.fillAddr[25:SET_LSB];
        end
    end

    // cycles spent holding the core during boot, only for checking
    logic [9:0] bootStallCnt;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bootStallCnt <= '0;
        end else if (q.kind == SCAN_BOOT && (q.state == ST_HOLD || q.state == ST_SCAN)) begin
            bootStallCnt <= bootStallCnt + 10'h001;
        end
    end

    logic [1:0] hitPair;
    logic       hitOdd;
    logic       lockStartIdle;
    assign hitPair = hitEnc[2:1];
    assign hitOdd = hitEnc[0];
    assign lockStartIdle = q.state == ST_IDLE && q.lockStart;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_bootLast;
        q.state == ST_SCAN && q.kind == SCAN_BOOT && q.cnt == SCAN_LAST;
    endsequence
    sequence s_lockStart;
        lockStartIdle;
    endsequence

    property p_nopHold;
        $rose(rst_b) |-> nopForce && pcLoad && coreStall ##1 !nopForce && coreStall;
    endproperty
    a_nopHold: assert property (p_nopHold) else $error("no nop hold after reset"); // see R09

    property p_bootLen;
        s_bootLast |-> bootStallCnt == 10'(BOOT_CYCLES) ##1 q.state == ST_IDLE;
    endproperty
    a_bootLen: assert property (p_bootLen) else $error("boot scan length wrong"); // see R11

    property p_bootStall;
        q.state == ST_SCAN |-> coreStall && !fetchHit;
    endproperty
    a_bootStall: assert property (p_bootStall) else $error("core not stalled in scan"); // see R10

    property p_bootVec;
        $rose(rst_b) |-> bootVector == APERTURE_BASE_RESET && q.lru[0] == LRU_INIT;
    endproperty
    a_bootVec: assert property (p_bootVec) else $error("boot vector or lru not reset"); // see R12

    property p_noLockedVictim;
        $rose(q.fillReq) |-> !q.locked[fillIdx] && !q.pend[fillIdx];
    endproperty
    a_noLockedVictim: assert property (p_noLockedVictim) else $error("locked victim"); // see R02

    property p_pairBit;
        fetchHit |=> q.lru[$past(fetchSet)][PAIR_LSB + int'($past(hitPair))] == !$past(hitOdd);
    endproperty
    a_pairBit: assert property (p_pairBit) else $error("pair bit not written"); // see R15

    property p_lockInv;
        s_lockStart |=> q.state == ST_SCAN && q.kind == SCAN_LOCK && q.cnt == 9'h000;
    endproperty
    a_lockInv: assert property (p_lockInv) else $error("lock did not start with scan"); // see R04

    property p_lockAct;
        $rose(|q.locked) |-> $past(q.state) == ST_LACT;
    endproperty
    a_lockAct: assert property (p_lockAct) else $error("lock active before preload"); // see R03

    property p_lockCap;
        q.state == ST_LREQ && lockedInSet >= MAX_LOCK_WAYS |=> !q.fillReq;
    endproperty
    a_lockCap: assert property (p_lockCap) else $error("fifth way locked"); // see R01

    property p_clrAll;
        q.state == ST_IDLE && !q.lockStart && iclrReq |=> q.locked == '0 && q.kind == SCAN_CLR;
    endproperty
    a_clrAll: assert property (p_clrAll) else $error("clear kept locked blocks"); // see R06

    property p_lockStall;
        q.state == ST_LREQ || q.state == ST_LACT |-> coreStall;
    endproperty
    a_lockStall: assert property (p_lockStall) else $error("core ran during preload"); // see R20
endmodule
`default_nettype wire

// [icl_fill_model.sv]
// main-memory fill path model: answers each block fill request with one done pulse
`default_nettype none
module icl_fill_model (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic slowMode,
    input  wire logic fillReq,
    output var  logic fillDone
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] waitCnt;
    logic [3:0] waitMax;
    // slow mode stretches each block fetch to exercise a long stall
    assign waitMax = slowMode ? 4'h6 : 4'h1;
    // one pulse per request, never while the request is withdrawn
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            waitCnt  <= 4'h0;
            fillDone <= 1'b0;
        end else if (fillReq && !fillDone && waitCnt >= waitMax) begin
            waitCnt  <= 4'h0;
            fillDone <= 1'b1;
        end else begin
            fillDone <= 1'b0;
            waitCnt  <= (fillReq && !fillDone) ? waitCnt + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

// [icl_ctrl_tb_top.sv]
// self-checking bench for the instruction cache lock, boot and replacement control
`default_nettype none
module icl_ctrl_tb_top import icl_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] BOOT_BASE = 32'h4000_0000;
    logic        clk, rst_b, regSel, regWrite, fetchReq, iclrReq, fillDone, slowMode;
    logic [23:0] regOffset;
    logic [31:0] regWdata, regRdata, fetchAddr, bootVector;
    logic        fetchHit, coreStall, nopForce, pcLoad, fillReq;
    logic [2:0]  hitWay, fillWay;
    logic [25:0] fillBlockAddr;
    int          failures, tests_run, cycles;

    icl_ctrl #(.APERTURE_BASE_RESET(BOOT_BASE)) dut_u (
        .clk(clk), .rst_b(rst_b), .regSel(regSel), .regWrite(regWrite),
        .regOffset(regOffset), .regWdata(regWdata), .regRdata(regRdata),
        .fetchReq(fetchReq), .fetchAddr(fetchAddr), .fetchHit(fetchHit), .hitWay(hitWay),
        .coreStall(coreStall), .nopForce(nopForce), .pcLoad(pcLoad), .bootVector(bootVector),
        .iclrReq(iclrReq), .fillReq(fillReq), .fillBlockAddr(fillBlockAddr),
        .fillWay(fillWay), .fillDone(fillDone));

    icl_fill_model fill_u (.clk(clk), .rst_b(rst_b), .slowMode(slowMode),
        .fillReq(fillReq), .fillDone(fillDone));

    // 40 MHz core clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // hang guard: the whole run needs well under ten thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("CHECK FAILED at %0t: run did not finish", $time);
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one register access; read data is taken in the cycle after the strobe
    task automatic reg_acc(input logic wr, input logic [23:0] ofs, input logic [31:0] wd,
                           output logic [31:0] rd);
        @(posedge clk);
        #1 regSel = 1'b1;
        regWrite  = wr;
        regOffset = ofs;
        regWdata  = wd;
        @(posedge clk);
        #1 regSel = 1'b0;
        @(negedge clk);
        rd = regRdata;
    endtask

    // fetch held until served; a miss shows one fill of the wanted block
    task automatic fetch(input logic [31:0] a, input logic expMiss, input logic [2:0] expWay,
                         input logic chkWay);
        logic missed;
        missed = 1'b0;
        @(posedge clk);
        #1 fetchReq = 1'b1;
        fetchAddr = a;
        for (int n = 0; n < 200; n++) begin
            @(negedge clk);
            if (fetchHit === 1'b1) break;
            if (fillReq === 1'b1 && !missed) begin
                missed = 1'b1;
                if (chkWay) chk(32'(fillWay), 32'(expWay));
                chk(32'(fillBlockAddr), 32'(a[31:6]));
            end
        end
        chk(32'(fetchHit), 32'h1);
        chk(32'(missed), 32'(expMiss));
        @(posedge clk);
        #1 fetchReq = 1'b0;
        @(negedge clk);
        if (chkWay) chk(32'(hitWay), 32'(expWay));
    endtask

    task automatic t_boot();
        int n;
        @(negedge clk);
        chk(32'(nopForce), 32'h1);
        chk(32'(pcLoad), 32'h1);
        chk(32'(coreStall), 32'h1);
        chk(bootVector, BOOT_BASE);
        @(posedge clk);
        #1 rst_b = 1'b1;
        @(negedge clk);
        chk(32'(nopForce), 32'h1);
        n = 0;
        while (coreStall === 1'b1 && n < 2000) begin
            n++;
            @(negedge clk);
        end
        chk(32'(n), 32'(BOOT_CYCLES + 1));
        chk(32'(nopForce), 32'h0);
        $display("test boot done");
    endtask

    task automatic t_regs();
        logic [23:0] ofs [4];
        logic [31:0] exp [4];
        logic [31:0] rd;
        ofs = '{OFS_LOCK_CTL, OFS_LOCK_BASE, OFS_LOCK_SIZE, 24'h10021C};
        exp = '{32'h0000_0000, 32'hFFFF_FFC0, 32'h0000_7FC0, 32'h0000_0000};
        // all ones, with the enable bit clear in the control write, so no lock sequence starts here
        for (int i = 0; i < 4; i++) begin
            reg_acc(1'b1, ofs[i], 32'hFFFF_FFFE | 32'(i != 0), rd);
            reg_acc(1'b0, ofs[i], 32'h0, rd);
            chk(rd, exp[i]);
        end
        reg_acc(1'b1, OFS_LOCK_BASE, 32'h0, rd);
        reg_acc(1'b1, OFS_LOCK_SIZE, 32'h0, rd);
        $display("test registers done");
    endtask

    task automatic t_lru();
        logic [2:0] vic [6];
        // victims worked out from the reset matrix and fills acting as references
        vic = '{3'h0, 3'h6, 3'h4, 3'h2, 3'h1, 3'h7};
        for (int i = 0; i < 6; i++) fetch({20'(i + 1), 12'h000}, 1'b1, vic[i], 1'b1);
        fetch({20'h00002, 12'h000}, 1'b0, 3'h6, 1'b1);
        $display("test replacement done");
    endtask

    task automatic t_lock();
        logic [31:0] rd;
        int n, nFill;
        // software keeps the locked code in one range from address zero
        reg_acc(1'b1, OFS_LOCK_BASE, 32'h0, rd);
        reg_acc(1'b1, OFS_LOCK_SIZE, 32'h0000_7FC0, rd);
        slowMode = 1'b1;
        reg_acc(1'b1, OFS_LOCK_CTL, 32'h1, rd);
        @(posedge clk);
        n = 0;
        nFill = 0;
        @(negedge clk);
        while (coreStall === 1'b1 && n < 8000) begin
            n++;
            if (fillDone === 1'b1) nFill++;
            @(negedge clk);
        end
        slowMode = 1'b0;
        chk(32'(nFill), 32'(MAX_LOCK_BLOCKS));
        chk(32'(n > 1280), 32'h1);
        for (int i = 0; i < 8; i++) fetch({20'(16 + i), 12'h000}, 1'b1, 3'h0, 1'b0);
        for (int t = 0; t < 4; t++) fetch({20'(t), 12'h000}, 1'b0, 3'h0, 1'b0);
        fetch(32'h0000_3FC0, 1'b0, 3'h0, 1'b0);
        $display("test lock done");
    endtask

    task automatic t_clear();
        logic [31:0] rd;
        int n;
        reg_acc(1'b1, OFS_LOCK_CTL, 32'h0, rd);
        @(posedge clk);
        #1 iclrReq = 1'b1;
        @(posedge clk);
        #1 iclrReq = 1'b0;
        @(negedge clk);
        chk(32'(coreStall), 32'h1);
        n = 0;
        while (coreStall === 1'b1 && n < 2000) begin
            n++;
            @(negedge clk);
        end
        // locked block is gone and the lru is back at its reset state
        fetch(32'h0000_0000, 1'b1, 3'h0, 1'b1);
        $display("test clear done");
    endtask

    initial begin
        rst_b = 1'b0;
        regSel = 1'b0;
        regWrite = 1'b0;
        regOffset = 24'h000000;
        regWdata = 32'h0;
        fetchReq = 1'b0;
        fetchAddr = 32'h0;
        iclrReq = 1'b0;
        slowMode = 1'b0;
        failures = 0;
        tests_run = 0;
        cycles = 0;
        @(posedge clk);
        t_boot();
        t_regs();
        t_lru();
        t_lock();
        t_clear();
        stop_test();
    end
endmodule
`default_nettype wire
